// file: logic/aer_regs.svh
// Purpose: Offsets, field positions, reset values of the error reporting bank
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes: Definitions only
`ifndef AER_REGS_SVH
`define AER_REGS_SVH
// Register byte offsets
`define AER_OFF_UNC_STS 12'h104
`define AER_OFF_UNC_MSK 12'h108
`define AER_OFF_UNC_SEV 12'h10C
`define AER_OFF_COR_STS 12'h110
`define AER_OFF_COR_MSK 12'h114
`define AER_OFF_CAP_CTL 12'h118
`define AER_OFF_HDR0 12'h11C
`define AER_OFF_HDR3 12'h128
`define AER_OFF_IRQ_STS 12'h130
`define AER_OFF_IRQ_MSK 12'h134
// Implemented bits and reset values
`define AER_UNC_IMPL 32'h001F_F011
`define AER_UNC_SEV_RST 32'h0006_2011
`define AER_COR_IMPL 32'h0000_31C1
`define AER_COR_MSK_RST 32'h0000_2000
// Capability and control fields
`define AER_FEP_MSB 4
`define AER_GEN_CAP 5
`define AER_GEN_EN 6
`define AER_CHK_CAP 7
`define AER_CHK_EN 8
// Interrupt status bits
`define AER_IRQ_UNC 0
`define AER_IRQ_COR 1
`define AER_IRQ_LOG 2
`define AER_IRQ_W 3
`endif

// file: logic/aer_pkg.sv
// Purpose: Types shared by the error reporting bank
// Assumes: Nothing beyond the header
// Notes: Message kinds follow the link's error message classes
package aer_pkg;
    // Error message class
    typedef enum logic [1:0] {
        AER_MSG_COR = 2'b00,
        AER_MSG_NONFATAL = 2'b01,
        AER_MSG_FATAL = 2'b11
    } aer_msg_t;
    // Reporter states
    typedef enum logic [0:0] {
        AER_ST_IDLE = 1'b0,
        AER_ST_SEND = 1'b1
    } aer_state_t;
endpackage : aer_pkg

// file: logic/aer_if.sv
// Purpose: Internal carrier for register access and error reports
// Assumes: Single clock domain
// Notes: One group per pairing of modules
`timescale 1ns/1ps
interface aer_if;
    // Register access group
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] wmask;
    logic [31:0] rdata;
    // Error report group, one-cycle pulses
    logic rep_cor;
    logic rep_nonfatal;
    logic rep_fatal;
    // Bus slave drives the access strobes
    modport bus_side (output wr, output rd, output addr, output wdata,
        output wmask, input rdata);
    // Register file answers them
    modport reg_side (input wr, input rd, input addr, input wdata,
        input wmask, output rdata, output rep_cor, output rep_nonfatal,
        output rep_fatal);
    // Reporter takes the pulses
    modport rpt_side (input rep_cor, input rep_nonfatal, input rep_fatal);
endinterface : aer_if

// file: logic/aer_wb_slave.sv
// Purpose: Classic Wishbone slave, one wait state per access
// Assumes: Master holds the request until ack
// Notes: Unmapped reads return zero, writes to them are dropped
`timescale 1ns/1ps
module aer_wb_slave (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Register side
    aer_if.bus_side rb
);
    logic ack_reg; // Ack flop, drops the cycle after it rose
    logic [31:0] dat_reg; // Read data flop
    logic req; // Live request not yet answered

    // Read is fetched the cycle before ack; a write lands on the ack edge
    assign req = cyc_i & stb_i & ~ack_reg;
    assign rb.wr = cyc_i & stb_i & we_i & ack_reg;
    assign rb.rd = req & ~we_i;
    assign rb.addr = adr_i;
    assign rb.wdata = dat_i;
    // Byte lanes expand to a bit mask
    assign rb.wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

    // Ack one cycle after the request appears
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // Read data captured with the ack
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dat_reg <= 32'h0000_0000;
        end else if (rb.rd) begin
            dat_reg <= rb.rdata;
        end
    end

    // Ack is never two cycles long
    a_ack_single: assert property (@(posedge clk_sys) disable iff (rst)
        ack_o |=> !ack_o) else $error("ack held two cycles");
endmodule : aer_wb_slave

// file: logic/aer_reporter.sv
// Purpose: Queues error messages and hands them to the link layer
// Assumes: Link layer takes a message with valid and ready
// Notes: Fatal beats non-fatal beats correctable when several wait
`timescale 1ns/1ps
module aer_reporter (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Report pulses
    aer_if.rpt_side rp,
    // Message port
    output logic msg_valid,
    output aer_pkg::aer_msg_t msg_kind,
    input wire logic msg_ready
);
    aer_pkg::aer_state_t state_reg; // Reporter state
    aer_pkg::aer_msg_t kind_reg; // Message being offered
    logic [2:0] pend_reg; // Waiting: fatal, non-fatal, correctable
    logic done; // Offered message taken

    assign done = (state_reg == aer_pkg::AER_ST_SEND) & msg_ready;
    assign msg_valid = (state_reg == aer_pkg::AER_ST_SEND);
    assign msg_kind = kind_reg;

    // Pending flags; a new report wins over the clear of the sent one
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_reg <= 3'h0;
        end else begin
            pend_reg <= (pend_reg & ~({3{done}} & {kind_reg == aer_pkg::AER_MSG_FATAL,
                kind_reg == aer_pkg::AER_MSG_NONFATAL, kind_reg == aer_pkg::AER_MSG_COR}))
                | {rp.rep_fatal, rp.rep_nonfatal, rp.rep_cor};
        end
    end

    // Pick the most severe waiting message, hold it until taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= aer_pkg::AER_ST_IDLE;
            kind_reg <= aer_pkg::AER_MSG_COR;
        end else begin
            case (state_reg)
                aer_pkg::AER_ST_IDLE: begin
                    if (pend_reg[2]) begin
                        kind_reg <= aer_pkg::AER_MSG_FATAL;
                        state_reg <= aer_pkg::AER_ST_SEND;
                    end else if (pend_reg[1]) begin
                        kind_reg <= aer_pkg::AER_MSG_NONFATAL;
                        state_reg <= aer_pkg::AER_ST_SEND;
                    end else if (pend_reg[0]) begin
                        kind_reg <= aer_pkg::AER_MSG_COR;
                        state_reg <= aer_pkg::AER_ST_SEND;
                    end
                end
                aer_pkg::AER_ST_SEND: begin
                    if (msg_ready) begin
                        state_reg <= aer_pkg::AER_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= aer_pkg::AER_ST_IDLE;
                end
            endcase
        end
    end

    // A fatal report is offered as fatal within a few cycles
    a_fatal_sent: assert property (@(posedge clk_sys) disable iff (rst) // [R19]
        rp.rep_fatal && !msg_valid && pend_reg == 3'h0
        |-> ##[1:2] (msg_valid && msg_kind == aer_pkg::AER_MSG_FATAL))
        else $error("fatal report not offered");
    // Offer stays put until taken
    a_msg_hold: assert property (@(posedge clk_sys) disable iff (rst)
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_kind))
        else $error("message dropped before ready");
endmodule : aer_reporter

// file: logic/aer_top.sv
// Purpose: Advanced error reporting register bank with header log
// Assumes: Error sources give one-cycle pulses with the TLP header alongside
// Notes: All sticky fields clear only on rst, the fundamental reset
// Function
// [R1] Severity bits sticky, fatal defaults for five types
// [R2] Receiver error sets correctable bit 0
// [R3] Bad TLP sets correctable bit 6
// [R4] Bad DLLP sets correctable bit 7
// [R5] Replay number rollover sets correctable bit 8
// [R6] Replay timer expiry sets correctable bit 12
// [R7] Advisory non-fatal error sets correctable bit 13
// [R8] Correctable mask blocks logging and message
// [R9] Advisory mask resets set, others clear
// [R10] First error pointer holds first uncorrectable bit
// [R11] Bit 5 reads one: ECRC generation capable
// [R12] Bit 6 enables ECRC generation, resets off
// [R13] Bit 7 reads one: ECRC check capable
// [R14] Bit 8 enables ECRC checking, resets off
// [R15] Four header dwords, first at lowest offset
// [R16] Uncorrectable status bits set, write one clears
// [R17] Uncorrectable mask blocks logging and reporting
// [R18] First logged error freezes header and pointer
// [R19] Severity bit selects fatal or non-fatal message
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "aer_regs.svh"
module aer_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [11:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Error detection pulses and the offending header
    input wire logic [31:0] unc_err_evt,
    input wire logic [31:0] cor_err_evt,
    input wire logic [127:0] err_hdr,
    // ECRC control to the transaction layer
    output logic ecrc_gen_en,
    output logic ecrc_chk_en,
    // Error messages toward the root complex
    output logic msg_valid,
    output aer_pkg::aer_msg_t msg_kind,
    input wire logic msg_ready,
    // Interrupt
    output logic irq
);
    aer_if bus ();

    // Sticky registers
    logic [31:0] unc_sts_reg; // Uncorrectable status
    logic [31:0] unc_msk_reg; // Uncorrectable mask
    logic [31:0] unc_sev_reg; // Uncorrectable severity
    logic [31:0] cor_sts_reg; // Correctable status
    logic [31:0] cor_msk_reg; // Correctable mask
    logic [4:0] fep_reg; // First error pointer
    logic gen_en_reg; // ECRC generation enable
    logic chk_en_reg; // ECRC check enable
    logic [31:0] hdr_reg [0:3]; // Header log dwords
    logic log_hold_reg; // Header log frozen
    logic log_unc_reg; // Frozen entry came from uncorrectable side
    logic [4:0] log_bit_reg; // Status bit that owns the frozen entry

    // Interrupt registers
    logic [`AER_IRQ_W-1:0] irq_sts_reg;
    logic [`AER_IRQ_W-1:0] irq_msk_reg;

    // Decoded access
    logic [31:0] clr; // Write-one-clear bits
    logic [31:0] unc_evt; // Implemented uncorrectable events
    logic [31:0] cor_evt; // Implemented correctable events
    logic [31:0] unc_live; // Unmasked uncorrectable events
    logic [31:0] cor_live; // Unmasked correctable events
    logic [4:0] unc_first; // Lowest unmasked uncorrectable bit
    logic [4:0] cor_first; // Lowest unmasked correctable bit
    logic owner_set; // Status bit behind the frozen log still set
    logic log_take; // Capture a header this cycle
    logic [31:0] cap_word; // Capability and control readback

    // Lowest set bit, used when several errors land together
    function automatic logic [4:0] aer_lowest(input logic [31:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                idx = 5'(i);
            end
        end
        return idx;
    endfunction : aer_lowest

    // Bus front end
    aer_wb_slave u_wb (
        .clk_sys(clk_sys),
        .rst(rst),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .rb(bus.bus_side)
    );

    // Message queue toward the root complex
    aer_reporter u_rpt (
        .clk_sys(clk_sys),
        .rst(rst),
        .rp(bus.rpt_side),
        .msg_valid(msg_valid),
        .msg_kind(msg_kind),
        .msg_ready(msg_ready)
    );

    // Event qualification; unimplemented positions never set
    assign unc_evt = unc_err_evt & `AER_UNC_IMPL;
    assign cor_evt = cor_err_evt & `AER_COR_IMPL;
    assign unc_live = unc_evt & ~unc_msk_reg; // [R17]
    assign cor_live = cor_evt & ~cor_msk_reg; // [R8]
    assign unc_first = aer_lowest(unc_live);
    assign cor_first = aer_lowest(cor_live);
    assign clr = bus.wdata & bus.wmask;

    // Reports; masked events never reach the reporter
    assign bus.rep_fatal = |(unc_live & unc_sev_reg); // [R19]
    assign bus.rep_nonfatal = |(unc_live & ~unc_sev_reg); // [R19]
    assign bus.rep_cor = |cor_live; // [R8]

    // Uncorrectable status, set wins over clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unc_sts_reg <= 32'h0000_0000;
        end else if (bus.wr && bus.addr == `AER_OFF_UNC_STS) begin
            unc_sts_reg <= (unc_sts_reg & ~clr) | unc_evt; // [R16]
        end else begin
            unc_sts_reg <= unc_sts_reg | unc_evt; // [R16]
        end
    end

    // Correctable status, one bit per detected event
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cor_sts_reg <= 32'h0000_0000;
        end else if (bus.wr && bus.addr == `AER_OFF_COR_STS) begin
            cor_sts_reg <= (cor_sts_reg & ~clr) | cor_evt; // [R2] [R3] [R4] [R5] [R6] [R7]
        end else begin
            cor_sts_reg <= cor_sts_reg | cor_evt; // [R2] [R3] [R4] [R5] [R6] [R7]
        end
    end

    // Masks and severity, byte-lane writes of implemented bits only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unc_msk_reg <= 32'h0000_0000; // [R17]
            unc_sev_reg <= `AER_UNC_SEV_RST; // [R1]
            cor_msk_reg <= `AER_COR_MSK_RST; // [R9]
        end else if (bus.wr) begin
            if (bus.addr == `AER_OFF_UNC_MSK) begin
                unc_msk_reg <= ((unc_msk_reg & ~bus.wmask) | clr) & `AER_UNC_IMPL;
            end
            if (bus.addr == `AER_OFF_UNC_SEV) begin
                unc_sev_reg <= ((unc_sev_reg & ~bus.wmask) | clr) & `AER_UNC_IMPL; // [R1]
            end
            if (bus.addr == `AER_OFF_COR_MSK) begin
                cor_msk_reg <= ((cor_msk_reg & ~bus.wmask) | clr) & `AER_COR_IMPL; // [R8]
            end
        end
    end

    // ECRC enables live in the low two byte lanes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gen_en_reg <= 1'b0; // [R12]
            chk_en_reg <= 1'b0; // [R14]
        end else if (bus.wr && bus.addr == `AER_OFF_CAP_CTL) begin
            if (bus.wmask[`AER_GEN_EN]) begin
                gen_en_reg <= bus.wdata[`AER_GEN_EN]; // [R12]
            end
            if (bus.wmask[`AER_CHK_EN]) begin
                chk_en_reg <= bus.wdata[`AER_CHK_EN]; // [R14]
            end
        end
    end

    // Straight to the transaction layer
    assign ecrc_gen_en = gen_en_reg; // [R12]
    assign ecrc_chk_en = chk_en_reg; // [R14]

    // Ownership check; the log unfreezes once its status bit is cleared
    assign owner_set = log_unc_reg ? unc_sts_reg[log_bit_reg]
        : cor_sts_reg[log_bit_reg];
    assign log_take = (~log_hold_reg | ~owner_set)
        & ((|unc_live) | (|cor_live)); // [R18]

    // Log ownership; uncorrectable errors take precedence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            log_hold_reg <= 1'b0;
            log_unc_reg <= 1'b0;
            log_bit_reg <= 5'h00;
        end else if (log_take) begin
            log_hold_reg <= 1'b1; // [R18]
            log_unc_reg <= |unc_live;
            log_bit_reg <= (|unc_live) ? unc_first : cor_first;
        end else if (log_hold_reg && !owner_set) begin
            log_hold_reg <= 1'b0; // [R18]
        end
    end

    // First error pointer follows uncorrectable captures only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fep_reg <= 5'h00; // [R10]
        end else if (log_take && (|unc_live)) begin
            fep_reg <= unc_first; // [R10] [R18]
        end
    end

    // Header capture, first wire byte in the top byte of each dword
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_hdr
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    hdr_reg[g] <= 32'h0000_0000;
                end else if (log_take) begin
                    hdr_reg[g] <= err_hdr[127-32*g -: 32]; // [R15] [R18]
                end
            end
        end
    endgenerate

    // Interrupt status; a new event beats a same-cycle clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_sts_reg <= 3'h0;
        end else begin
            irq_sts_reg <= (irq_sts_reg & ~((bus.wr && bus.addr == `AER_OFF_IRQ_STS)
                ? clr[`AER_IRQ_W-1:0] : 3'h0))
                | {log_take, |cor_live, |unc_live};
        end
    end

    // Interrupt mask, a one blocks the matching status bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_msk_reg <= 3'h0;
        end else if (bus.wr && bus.addr == `AER_OFF_IRQ_MSK) begin
            irq_msk_reg <= (irq_msk_reg & ~bus.wmask[`AER_IRQ_W-1:0])
                | clr[`AER_IRQ_W-1:0];
        end
    end

    // Level, not a pulse
    assign irq = |(irq_sts_reg & ~irq_msk_reg);

    // Capability word; capable bits are wired high
    assign cap_word = {23'h00_0000, chk_en_reg, 1'b1, // [R13]
        gen_en_reg, 1'b1, fep_reg}; // [R11]

    // Read mux, unmapped offsets read zero
    always_comb begin
        case (bus.addr)
            `AER_OFF_UNC_STS: bus.rdata = unc_sts_reg;
            `AER_OFF_UNC_MSK: bus.rdata = unc_msk_reg;
            `AER_OFF_UNC_SEV: bus.rdata = unc_sev_reg;
            `AER_OFF_COR_STS: bus.rdata = cor_sts_reg;
            `AER_OFF_COR_MSK: bus.rdata = cor_msk_reg;
            `AER_OFF_CAP_CTL: bus.rdata = cap_word;
            `AER_OFF_HDR0: bus.rdata = hdr_reg[0]; // [R15]
            12'h120: bus.rdata = hdr_reg[1]; // [R15]
            12'h124: bus.rdata = hdr_reg[2]; // [R15]
            `AER_OFF_HDR3: bus.rdata = hdr_reg[3]; // [R15]
            `AER_OFF_IRQ_STS: bus.rdata = {29'h0000_0000, irq_sts_reg};
            `AER_OFF_IRQ_MSK: bus.rdata = {29'h0000_0000, irq_msk_reg};
            default: bus.rdata = 32'h0000_0000;
        endcase
    end

    // Checks on the bank's behaviour
    // Each implemented correctable event, and uncorrectable bit 20, must land in its own status bit
    a_unc_set: assert property (@(posedge clk_sys) disable iff (rst) // [R16]
        unc_err_evt[20] |=> unc_sts_reg[20])
        else $error("unsupported request not recorded");

    a_rx_err_set: assert property (@(posedge clk_sys) disable iff (rst) // [R2]
        cor_err_evt[0] |=> cor_sts_reg[0])
        else $error("receiver error not recorded");

    a_bad_tlp_set: assert property (@(posedge clk_sys) disable iff (rst) // [R3]
        cor_err_evt[6] |=> cor_sts_reg[6])
        else $error("bad TLP not recorded");

    a_bad_dllp_set: assert property (@(posedge clk_sys) disable iff (rst) // [R4]
        cor_err_evt[7] |=> cor_sts_reg[7])
        else $error("bad DLLP not recorded");

    a_rollover_set: assert property (@(posedge clk_sys) disable iff (rst) // [R5]
        cor_err_evt[8] |=> cor_sts_reg[8])
        else $error("rollover not recorded");

    a_timer_set: assert property (@(posedge clk_sys) disable iff (rst) // [R6]
        cor_err_evt[12] |=> cor_sts_reg[12])
        else $error("replay timeout not recorded");

    a_advisory_set: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
        cor_err_evt[13] |=> cor_sts_reg[13])
        else $error("advisory error not recorded");

    a_masked_quiet: assert property (@(posedge clk_sys) disable iff (rst) // [R8]
        (cor_evt != 0 && cor_live == 0 && unc_live == 0) |-> !bus.rep_cor && !log_take)
        else $error("masked error reported");

    a_unc_masked: assert property (@(posedge clk_sys) disable iff (rst) // [R17]
        (unc_evt != 0 && unc_live == 0) |-> !bus.rep_fatal && !bus.rep_nonfatal)
        else $error("masked uncorrectable error reported");

    a_log_frozen: assert property (@(posedge clk_sys) disable iff (rst) // [R18]
        log_hold_reg && owner_set |=> $stable(hdr_reg[0]) && $stable(fep_reg))
        else $error("header log overwritten while held");

    a_fep_first: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
        log_take && (|unc_live) |=> fep_reg == $past(unc_first) && log_hold_reg)
        else $error("pointer misses first error");

    a_ecrc_drive: assert property (@(posedge clk_sys) disable iff (rst) // [R14]
        bus.wr && bus.addr == `AER_OFF_CAP_CTL && bus.wmask[`AER_CHK_EN]
        |=> ecrc_chk_en == $past(bus.wdata[`AER_CHK_EN]))
        else $error("check enable not applied");
endmodule : aer_top

// file: tb/aer_rc_model.sv
// Purpose: Root complex end that takes error messages
// Assumes: A message is taken on an edge with valid and ready high
// Notes: Slow mode accepts every other cycle to stall the reporter
`timescale 1ns/1ps
module aer_rc_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Message port
    input wire logic msg_valid,
    input wire aer_pkg::aer_msg_t msg_kind,
    input wire logic slow,
    output logic msg_ready,
    // Record of taken messages
    output aer_pkg::aer_msg_t last_kind,
    output logic [7:0] taken_cnt
);
    // Ready toggles when slow, so a held offer must survive stalls
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            msg_ready <= 1'b0;
        end else begin
            msg_ready <= slow ? ~msg_ready : 1'b1;
        end
    end
    // Count and keep the kind of every message taken
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_kind <= aer_pkg::AER_MSG_COR;
            taken_cnt <= 8'h00;
        end else if (msg_valid && msg_ready) begin
            last_kind <= msg_kind;
            taken_cnt <= taken_cnt + 8'h01;
        end
    end
endmodule : aer_rc_model

// file: tb/pcie_advanced_error_reporting_regs_bench.sv
// Purpose: Self-checking bench for the error reporting bank
// Assumes: Bus answers within a few cycles
// Notes: Reset table first, then event cases by hand
`timescale 1ns/1ps
module pcie_advanced_error_reporting_regs_bench;
    // Design stimulus and responses
    logic clk_sys = 1'b0, rst = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, slow = 1'b0;
    logic [11:0] adr_i = 12'h000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rd, unc_err_evt = '0, cor_err_evt = '0;
    logic [127:0] err_hdr = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, hdr;
    logic ack_o, ecrc_gen_en, ecrc_chk_en, msg_valid, msg_ready, irq;
    aer_pkg::aer_msg_t msg_kind, last_kind;
    logic [7:0] taken_cnt;
    int fail_count = 0, samples_checked = 0;
    int cbits [6] = '{0, 6, 7, 8, 12, 13};
    // Rows: address beside reset value
    logic [43:0] rows [10] = '{{12'h10C, 32'h0006_2011}, {12'h110, 32'h0000_0000},
        {12'h114, 32'h0000_2000}, {12'h118, 32'h0000_00A0}, {12'h11C, 32'h0000_0000},
        {12'h120, 32'h0000_0000}, {12'h124, 32'h0000_0000}, {12'h128, 32'h0000_0000},
        {12'h108, 32'h0000_0000}, {12'h200, 32'h0000_0000}};
    aer_top i_aer_top (.clk_sys(clk_sys), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .unc_err_evt(unc_err_evt), .cor_err_evt(cor_err_evt),
        .err_hdr(err_hdr), .ecrc_gen_en(ecrc_gen_en), .ecrc_chk_en(ecrc_chk_en),
        .msg_valid(msg_valid), .msg_kind(msg_kind), .msg_ready(msg_ready), .irq(irq));
    aer_rc_model i_aer_rc_model (.clk_sys(clk_sys), .rst(rst), .msg_valid(msg_valid),
        .msg_kind(msg_kind), .slow(slow), .msg_ready(msg_ready), .last_kind(last_kind),
        .taken_cnt(taken_cnt));
    // 20 MHz clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // Verdict and end of run
    task automatic final_report;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    // Compare with unknowns treated as mismatches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle; entered just after an edge, holds until ack
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        chk({31'h0, ack_o}, 32'h0000_0001);
        if (ack_o !== 1'b1) final_report();
        @(posedge clk_sys);
    endtask : wb
    // One-cycle error pulses, then let status settle
    task automatic pulse(input logic [31:0] u, input logic [31:0] c);
        unc_err_evt <= u;
        cor_err_evt <= c;
        @(posedge clk_sys);
        unc_err_evt <= '0;
        cor_err_evt <= '0;
        repeat (2) @(posedge clk_sys);
    endtask : pulse
    // Bounded wait for the next message, then check its kind
    task automatic wait_msg(input logic [7:0] cnt, input aer_pkg::aer_msg_t k);
        int n;
        n = 0;
        while (taken_cnt === cnt && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        chk({22'h0, taken_cnt, last_kind}, {22'h0, cnt + 8'h01, k});
        if (n >= 20) final_report();
    endtask : wait_msg
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk({28'h0, irq, msg_valid, ecrc_gen_en, ecrc_chk_en}, 32'h0000_0000);
        foreach (rows[i]) begin
            wb(1'b0, rows[i][43:32], 32'h0000_0000);
            chk(rd, rows[i][31:0]);
        end
        // Each correctable source sets its bit, write one clears it
        foreach (cbits[i]) begin
            pulse(32'h0, 32'h1 << cbits[i]);
            wb(1'b0, 12'h110, 32'h0);
            chk(rd, 32'h1 << cbits[i]);
            wb(1'b1, 12'h110, 32'h1 << cbits[i]);
            wb(1'b0, 12'h110, 32'h0);
            chk(rd, 32'h0000_0000);
        end
        chk({22'h0, taken_cnt, last_kind}, {22'h0, 8'h05, aer_pkg::AER_MSG_COR});
        chk({31'h0, irq}, 32'h0000_0001);
        wb(1'b1, 12'h134, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0000_0000);
        wb(1'b1, 12'h130, 32'h0000_0007);
        wb(1'b1, 12'h134, 32'h0000_0000);
        // Fatal error logs header and pointer
        hdr = err_hdr;
        pulse(32'h0004_0000, 32'h0);
        wait_msg(8'h05, aer_pkg::AER_MSG_FATAL);
        for (int i = 0; i < 4; i++) begin
            wb(1'b0, 12'h11C + 12'(4 * i), 32'h0);
            chk(rd, hdr[127 - 32 * i -: 32]);
        end
        wb(1'b0, 12'h118, 32'h0);
        chk(rd, 32'h0000_00B2);
        // Later error leaves the log frozen
        err_hdr <= ~hdr;
        pulse(32'h0010_0000, 32'h0);
        wait_msg(8'h06, aer_pkg::AER_MSG_NONFATAL);
        wb(1'b0, 12'h11C, 32'h0);
        chk(rd, hdr[127:96]);
        wb(1'b1, 12'h104, 32'hFFFF_FFFF);
        wb(1'b0, 12'h104, 32'h0);
        chk(rd, 32'h0000_0000);
        // ECRC enables reach the pins
        wb(1'b1, 12'h118, 32'hFFFF_FFFF);
        chk({30'h0, ecrc_gen_en, ecrc_chk_en}, 32'h0000_0003);
        wb(1'b0, 12'h118, 32'h0);
        chk(rd & 32'hFFFF_FFE0, 32'h0000_01E0);
        // Severity keeps implemented bits; stalled partner still gets fatal
        wb(1'b1, 12'h10C, 32'hFFFF_FFFF);
        wb(1'b0, 12'h10C, 32'h0);
        chk(rd, 32'h001F_F011);
        slow <= 1'b1;
        pulse(32'h0000_1000, 32'h0);
        wait_msg(8'h07, aer_pkg::AER_MSG_FATAL);
        // Masked uncorrectable error sets status but sends nothing
        wb(1'b1, 12'h108, 32'h0000_0010);
        pulse(32'h0000_0010, 32'h0);
        repeat (6) @(posedge clk_sys);
        chk({24'h0, taken_cnt}, 32'h0000_0008);
        wb(1'b0, 12'h104, 32'h0);
        chk(rd & 32'h0000_0010, 32'h0000_0010);
        final_report();
    end
endmodule : pcie_advanced_error_reporting_regs_bench
